// ===== design/fsrc_pkg.sv
// constants for the sequencer ram enable and flash status register block
package fsrc_pkg;
  // register byte addresses on the peripheral bus
  localparam logic [31:0] RAME_ADDR = 32'hffa1_0054;
  localparam logic [31:0] STATUS_ADDR = 32'hffa1_0080;
  localparam logic [31:0] DUMMY_ECC_ADDR = 32'hffa1_0084;
  // ram enable register layout
  localparam logic [7:0] RAME_KEY_VALUE = 8'hc4;
  localparam int RAME_KEY_MSB = 15;
  localparam int RAME_KEY_LSB = 8;
  localparam int RAME_TRAN_BIT = 1;
  localparam int RAME_ENABLE_BIT = 0;
  localparam logic [15:0] RAME_RESET = 16'h0000;
  // flash status register layout
  localparam int STAT_ECC_BUFFER_FULL_BIT = 18;
  localparam int STAT_DTCT_BIT = 17;
  localparam int STAT_CRCT_BIT = 16;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  // command codes seen on the command start strobe
  localparam logic [3:0] CMD_PROGRAM = 4'h1;
  localparam logic [3:0] CMD_BLOCK_ERASE = 4'h2;
  localparam logic [3:0] CMD_LOCKBIT_PROGRAM = 4'h3;
  localparam logic [3:0] CMD_LOCKBIT_READ = 4'h4;
  localparam logic [3:0] CMD_OTP_SET = 4'h5;
  localparam logic [3:0] CMD_STATUS_CLEAR = 4'h6;
  localparam logic [3:0] CMD_FORCED_STOP = 4'h7;
  // otp read tracking states
  typedef enum logic [2:0]
  {
    FSRC_OTP_IDLE = 3'b001,
    FSRC_OTP_READ = 3'b010,
    FSRC_OTP_LOCK = 3'b100
  } fsrc_otp_e;
endpackage

// ===== design/fsrc_ctrl_status.sv
// sequencer ram enable register, ecc buffer and otp error monitor flags
`timescale 1ns/10ps
`default_nettype none
// What this block does
// [RQ1] key field never stored, reads zero
// [RQ2] control bits change only with key c4
// [RQ3] transfer mode one blocks ram reads
// [RQ4] enable bit zero blocks all ram access
// [RQ5] host stops sequencer before ram writes
// [RQ6] reserved bits 7..2 read reset value
// [RQ7] rom variant has no enable register
// [RQ8] status bits 31..19 read reset value
// [RQ9] buffer full set on fill, cleared empty; the code sets it only on a fill while program_active
// [RQ10] ecc disable routes dummy register to buffer
// [RQ11] dummy write while full stalls bus
// [RQ12] otp double error sets flag, locks
// [RQ13] code flash commands read otp value
// [RQ14] otp single correction flags, no lock
// [RQ15] status clear or stop clears otp flags
// [RQ16] wrong key changes nothing, no error
module fsrc_ctrl_status
  import fsrc_pkg::*;
#(
  parameter bit SEQ_ROM_VARIANT = 1'b0,
  parameter int ECC_W = 32
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [31:0] pbus_addr,
  input wire logic pbus_rd,
  input wire logic pbus_wr,
  input wire logic [31:0] pbus_wdata,
  output logic [31:0] pbus_rdata,
  output logic pbus_ack,
  output logic pbus_wait,
  input wire logic ram_rd_req,
  input wire logic ram_wr_req,
  output logic ram_rd_grant,
  output logic ram_wr_grant,
  output logic ram_high_speed,
  input wire logic ecc_disable_bit,
  input wire logic program_active,
  input wire logic ecc_hw_load,
  input wire logic [ECC_W-1:0] ecc_hw_data,
  input wire logic ecc_buf_take,
  output logic [ECC_W-1:0] ecc_buf_data,
  input wire logic cmd_start,
  input wire logic [3:0] cmd_code,
  input wire logic target_code_flash,
  output logic otp_read_req,
  input wire logic otp_read_done,
  input wire logic otp_err_double,
  input wire logic otp_err_single,
  output logic command_lock
);

  logic ram_transfer_mode;
  logic ram_access_enable;
  logic ecc_buffer_full;
  logic otp_double_error_flag;
  logic otp_single_corrected_flag;
  fsrc_otp_e otp_state;
  fsrc_otp_e next_otp_state;
  logic sel_rame;
  logic sel_status;
  logic sel_dummy;
  logic wr_go;
  logic key_ok;
  logic dummy_load;
  logic buf_load;
  logic otp_cmd;
  logic clear_cmd;
  logic [31:0] next_rdata;

  // address decode; the enable register vanishes on the rom variant
  assign sel_rame = (pbus_addr == RAME_ADDR) && !SEQ_ROM_VARIANT; // see [RQ7]
  assign sel_status = pbus_addr == STATUS_ADDR;
  assign sel_dummy = pbus_addr == DUMMY_ECC_ADDR;
  assign key_ok = pbus_wdata[RAME_KEY_MSB:RAME_KEY_LSB] == RAME_KEY_VALUE;

  // wait states hold a dummy write until the buffer drains
  assign pbus_wait = pbus_wr && sel_dummy && ecc_disable_bit && ecc_buffer_full; // see [RQ11]
  assign wr_go = pbus_wr && !pbus_wait;

  // key must arrive in the same access; a wrong key is silently dropped
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ram_transfer_mode <= RAME_RESET[RAME_TRAN_BIT];
      ram_access_enable <= RAME_RESET[RAME_ENABLE_BIT];
    end
    else if (wr_go && sel_rame && key_ok) // see [RQ2] see [RQ16]
    begin
      ram_transfer_mode <= pbus_wdata[RAME_TRAN_BIT];
      ram_access_enable <= pbus_wdata[RAME_ENABLE_BIT];
    end
  end

  // ram access gating; the host is trusted to stop the sequencer first
  always_comb
  begin
    ram_rd_grant = ram_rd_req && ram_access_enable && !ram_transfer_mode; // see [RQ3] see [RQ4]
    ram_wr_grant = ram_wr_req && ram_access_enable; // see [RQ4] see [RQ5]
    ram_high_speed = ram_access_enable && ram_transfer_mode; // see [RQ3]
  end

  // read data; key and reserved fields are constant zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (sel_rame)
    begin
      next_rdata[RAME_TRAN_BIT] = ram_transfer_mode; // see [RQ1] see [RQ6]
      next_rdata[RAME_ENABLE_BIT] = ram_access_enable;
    end
    else if (sel_status)
    begin
      next_rdata = STATUS_RESET; // see [RQ8]
      next_rdata[STAT_ECC_BUFFER_FULL_BIT] = ecc_buffer_full;
      next_rdata[STAT_DTCT_BIT] = otp_double_error_flag;
      next_rdata[STAT_CRCT_BIT] = otp_single_corrected_flag;
    end
  end

  // registered answer, one cycle after the access is taken
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pbus_rdata <= 32'h0000_0000;
      pbus_ack <= 1'b0;
    end
    else
    begin
      pbus_ack <= pbus_rd || wr_go;
      pbus_rdata <= pbus_rd ? next_rdata : 32'h0000_0000;
    end
  end

  // buffer source: dummy register under ecc disable, else the ecc generator
  assign dummy_load = wr_go && sel_dummy && ecc_disable_bit; // see [RQ10]
  assign buf_load = ecc_disable_bit ? dummy_load : ecc_hw_load;

  always_ff @(posedge core_clk)
  begin
    if (reset)
      ecc_buf_data <= '0;
    else if (buf_load && !ecc_buffer_full)
      ecc_buf_data <= ecc_disable_bit ? pbus_wdata[ECC_W-1:0] : ecc_hw_data;
  end

  // full flag; a fill while program_active in the same cycle as a drain leaves it set
  always_ff @(posedge core_clk)
  begin
    if (reset)
      ecc_buffer_full <= 1'b0;
    else if (buf_load && program_active)
      ecc_buffer_full <= 1'b1; // see [RQ9]
    else if (ecc_buf_take)
      ecc_buffer_full <= 1'b0; // see [RQ9]
  end

  // which commands read the otp value, and which clear the monitors
  assign otp_cmd = cmd_start && target_code_flash &&
                   (cmd_code == CMD_PROGRAM || cmd_code == CMD_BLOCK_ERASE ||
                    cmd_code == CMD_LOCKBIT_PROGRAM || cmd_code == CMD_LOCKBIT_READ ||
                    cmd_code == CMD_OTP_SET); // see [RQ13]
  assign clear_cmd = cmd_start &&
                     (cmd_code == CMD_STATUS_CLEAR || cmd_code == CMD_FORCED_STOP);

  // otp read tracking; a double error parks here until cleared
  always_comb
  begin
    case (otp_state)
      FSRC_OTP_IDLE:
        next_otp_state = otp_cmd ? FSRC_OTP_READ : FSRC_OTP_IDLE;
      FSRC_OTP_READ:
        if (otp_read_done && otp_err_double)
          next_otp_state = FSRC_OTP_LOCK; // see [RQ12]
        else if (otp_read_done || clear_cmd)
          next_otp_state = FSRC_OTP_IDLE; // see [RQ14]
        else
          next_otp_state = FSRC_OTP_READ;
      FSRC_OTP_LOCK:
        next_otp_state = clear_cmd ? FSRC_OTP_IDLE : FSRC_OTP_LOCK;
      default:
        next_otp_state = FSRC_OTP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      otp_state <= FSRC_OTP_IDLE;
    else
      otp_state <= next_otp_state;
  end

  assign otp_read_req = otp_state == FSRC_OTP_READ;
  assign command_lock = otp_state == FSRC_OTP_LOCK;

  // monitor flags; a detection beats a clear started in the same cycle
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      otp_double_error_flag <= 1'b0;
      otp_single_corrected_flag <= 1'b0;
    end
    else
    begin
      if (otp_read_req && otp_read_done && otp_err_double)
        otp_double_error_flag <= 1'b1; // see [RQ12]
      else if (clear_cmd)
        otp_double_error_flag <= 1'b0; // see [RQ15]
      if (otp_read_req && otp_read_done && otp_err_single && !otp_err_double)
        otp_single_corrected_flag <= 1'b1; // see [RQ14]
      else if (clear_cmd)
        otp_single_corrected_flag <= 1'b0; // see [RQ15]
    end
  end

  // checks
  chk_key_reads_zero: assert property (@(posedge core_clk) disable iff (reset) // see [RQ1]
    pbus_rd && sel_rame |=> pbus_rdata[RAME_KEY_MSB:2] == 14'h0000)
    else $error("key or reserved field read nonzero");

  chk_wrong_key_hold: assert property (@(posedge core_clk) disable iff (reset) // see [RQ16]
    pbus_wr && !key_ok |=> $stable(ram_transfer_mode) && $stable(ram_access_enable))
    else $error("control bits changed without key");

  chk_key_write_takes: assert property (@(posedge core_clk) disable iff (reset) // see [RQ2]
    wr_go && sel_rame && key_ok |=> ram_access_enable == $past(pbus_wdata[RAME_ENABLE_BIT]))
    else $error("keyed write not taken");

  chk_high_speed_read: assert property (@(posedge core_clk) disable iff (reset) // see [RQ3]
    ram_transfer_mode |-> !ram_rd_grant)
    else $error("ram read granted in high speed mode");

  chk_disabled_ram: assert property (@(posedge core_clk) disable iff (reset) // see [RQ4]
    ram_wr_req && !ram_access_enable |-> !ram_wr_grant && !ram_rd_grant)
    else $error("ram access while disabled");

  chk_status_reserved: assert property (@(posedge core_clk) disable iff (reset) // see [RQ8]
    pbus_rd && sel_status |=> pbus_rdata[31:19] == 13'h0000 && pbus_rdata[15:0] == 16'h0000)
    else $error("status reserved bits nonzero");

  chk_buffer_full_wait: assert property (@(posedge core_clk) disable iff (reset) // see [RQ11]
    pbus_wr && sel_dummy && ecc_disable_bit && ecc_buffer_full |-> pbus_wait ##1 !pbus_ack)
    else $error("dummy write not stalled while full");

  chk_buffer_fill: assert property (@(posedge core_clk) disable iff (reset) // see [RQ9]
    buf_load && program_active |=> ecc_buffer_full)
    else $error("buffer full flag not set");

  chk_double_locks: assert property (@(posedge core_clk) disable iff (reset) // see [RQ12]
    otp_read_req && otp_read_done && otp_err_double
      |=> otp_double_error_flag && command_lock)
    else $error("double error did not lock");

  chk_single_no_lock: assert property (@(posedge core_clk) disable iff (reset) // see [RQ14]
    otp_read_req && otp_read_done && otp_err_single && !otp_err_double
      |=> otp_single_corrected_flag && !command_lock)
    else $error("single correction mishandled");

  chk_clear_flags: assert property (@(posedge core_clk) disable iff (reset) // see [RQ15]
    clear_cmd && !otp_read_req |=> !otp_double_error_flag && !otp_single_corrected_flag)
    else $error("otp flags not cleared");

  chk_otp_read_cmd: assert property (@(posedge core_clk) disable iff (reset) // see [RQ13]
    otp_cmd && otp_state == FSRC_OTP_IDLE |=> otp_read_req)
    else $error("otp read not started");

  // readback, acknowledge and flag lifetimes
  chk_rame_readback: assert property (@(posedge core_clk) disable iff (reset) // see [RQ2]
    pbus_rd && sel_rame
      |=> pbus_rdata[1:0] == {$past(ram_transfer_mode), $past(ram_access_enable)})
    else $error("control bits read back wrong");

  chk_wrong_key_acked: assert property (@(posedge core_clk) disable iff (reset) // see [RQ16]
    pbus_wr && sel_rame && !key_ok && !pbus_wait |=> pbus_ack)
    else $error("wrong key write not acknowledged");

  chk_rom_no_register: assert property (@(posedge core_clk) disable iff (reset) // see [RQ7]
    SEQ_ROM_VARIANT |-> !ram_access_enable && !ram_transfer_mode)
    else $error("rom variant holds control bits");

  chk_stall_keeps_data: assert property (@(posedge core_clk) disable iff (reset) // see [RQ11]
    pbus_wait |=> $stable(ecc_buf_data))
    else $error("buffer overwritten during stall");

  chk_take_empties: assert property (@(posedge core_clk) disable iff (reset) // see [RQ9]
    ecc_buf_take && !(buf_load && program_active) |=> !ecc_buffer_full)
    else $error("buffer full flag not cleared");

  chk_lock_holds: assert property (@(posedge core_clk) disable iff (reset) // see [RQ12]
    command_lock && !clear_cmd |=> command_lock)
    else $error("command lock lost without clear");

  chk_lock_released: assert property (@(posedge core_clk) disable iff (reset) // see [RQ15]
    command_lock && clear_cmd |=> !command_lock && !otp_double_error_flag)
    else $error("clear did not release lock");

endmodule
`default_nettype wire

// ===== test/fsrc_host_model.sv
// host processor model issuing single peripheral bus accesses
`timescale 1ns/10ps
`default_nettype none
module fsrc_host_model
  import fsrc_pkg::*;
(
  input wire logic core_clk,
  output logic [31:0] pbus_addr,
  output logic pbus_rd,
  output logic pbus_wr,
  output logic [31:0] pbus_wdata,
  input wire logic [31:0] pbus_rdata,
  input wire logic pbus_ack,
  input wire logic pbus_wait
);
  // bus idle at time zero
  initial
  begin
    {pbus_rd, pbus_wr} = 2'h0;
    pbus_addr = 32'h0;
    pbus_wdata = 32'h0;
  end
  // one access, held to the taken edge; sequencer assumed stopped before ram use
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic k);
    int n;
    @(negedge core_clk);
    pbus_addr = a;
    pbus_wdata = (a == RAME_ADDR) ? {d[31:8], 6'h00, d[1:0]} : d;
    pbus_rd = !w;
    pbus_wr = w;
    // hold through wait states until the answer shows; bounded so a lost ack is seen
    n = 0;
    @(negedge core_clk);
    while (!pbus_ack && n < 20)
    begin
      n++;
      @(negedge core_clk);
    end
    q = pbus_rdata;
    k = pbus_ack;
    {pbus_rd, pbus_wr} = 2'h0;
    pbus_addr = ~a; // released lines carry no stale value
    pbus_wdata = ~pbus_wdata;
  endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the ram enable and flash status block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module testbench
  import fsrc_pkg::*;
;
  typedef struct packed {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] e;} fsrc_row_s;
  logic core_clk, reset, pbus_rd, pbus_wr, pbus_ack, pbus_wait, ram_rd_req, ram_wr_req;
  logic ram_rd_grant, ram_wr_grant, ram_high_speed, ecc_disable_bit, program_active;
  logic ecc_hw_load, ecc_buf_take, cmd_start, target_code_flash, otp_read_req;
  logic otp_read_done, otp_err_double, otp_err_single, command_lock, k;
  logic [31:0] pbus_addr, pbus_wdata, pbus_rdata, ecc_hw_data, ecc_buf_data, q;
  logic [3:0] cmd_code;
  logic [31:0] rom_rdata;
  int errors, tests_run;
  fsrc_row_s rows [8] = '{'{1'b0, RAME_ADDR, 32'h0, 32'h0}, '{1'b1, RAME_ADDR, 32'h0000_0003, 32'h0},
    '{1'b0, RAME_ADDR, 32'h0, 32'h0}, '{1'b1, RAME_ADDR, 32'h0000_c401, 32'h0},
    '{1'b0, RAME_ADDR, 32'h0, 32'h0000_0001}, '{1'b1, RAME_ADDR, 32'h0000_3a02, 32'h0},
    '{1'b0, RAME_ADDR, 32'h0, 32'h0000_0001}, '{1'b0, 32'hffa1_0090, 32'h0, 32'h0}};

  fsrc_ctrl_status fsrc_ctrl_status_inst (.core_clk, .reset, .pbus_addr, .pbus_rd, .pbus_wr,
    .pbus_wdata, .pbus_rdata, .pbus_ack, .pbus_wait, .ram_rd_req, .ram_wr_req, .ram_rd_grant,
    .ram_wr_grant, .ram_high_speed, .ecc_disable_bit, .program_active, .ecc_hw_load,
    .ecc_hw_data, .ecc_buf_take, .ecc_buf_data, .cmd_start, .cmd_code, .target_code_flash,
    .otp_read_req, .otp_read_done, .otp_err_double, .otp_err_single, .command_lock);
  fsrc_host_model fsrc_host_model_inst (.core_clk, .pbus_addr, .pbus_rd, .pbus_wr,
    .pbus_wdata, .pbus_rdata, .pbus_ack, .pbus_wait);
  // rom variant on the same bus; its enable register must be absent
  if (1)
  begin : rom_variant
    fsrc_ctrl_status #(.SEQ_ROM_VARIANT(1'b1)) fsrc_ctrl_status_inst (.core_clk, .reset,
      .pbus_addr, .pbus_rd, .pbus_wr, .pbus_wdata, .pbus_rdata(rom_rdata), .pbus_ack(),
      .pbus_wait(), .ram_rd_req, .ram_wr_req, .ram_rd_grant(), .ram_wr_grant(),
      .ram_high_speed(), .ecc_disable_bit, .program_active, .ecc_hw_load, .ecc_hw_data,
      .ecc_buf_take, .ecc_buf_data(), .cmd_start, .cmd_code, .target_code_flash,
      .otp_read_req(), .otp_read_done, .otp_err_double, .otp_err_single, .command_lock());
  end

  // 200 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // watchdog, far beyond the hundred or so cycles the run needs
  initial
  begin
    repeat (5000) @(posedge core_clk);
    errors++;
    give_verdict();
  end
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    fsrc_host_model_inst.xfer(w, a, d, q, k);
    `CHK("ack", 1, k);
  endtask
  task automatic cmd(input logic [3:0] c);
    @(negedge core_clk);
    cmd_code = c;
    cmd_start = 1'b1;
    @(negedge core_clk);
    cmd_start = 1'b0;
  endtask
  task automatic give_verdict();
    if (errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence
  initial
  begin
    reset = 1'b1;
    {ram_rd_req, ram_wr_req, ecc_disable_bit, program_active, ecc_hw_load, ecc_buf_take} = 6'h0;
    {cmd_start, target_code_flash, otp_read_done, otp_err_double, otp_err_single} = 5'h0;
    {cmd_code, ecc_hw_data} = 36'h0;
    repeat (10) @(negedge core_clk);
    reset = 1'b0;
    foreach (rows[i])
    begin
      acc(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
      begin
        `CHK("row read", rows[i].e, q);
        `CHK("rom read", 0, rom_rdata);
      end
    end
    // every enable and transfer mode pairing
    for (int m = 0; m < 4; m++)
    begin
      acc(1'b1, RAME_ADDR, 32'h0000_c400 | m);
      {ram_rd_req, ram_wr_req} = 2'h3;
      #1;
      `CHK("rd grant", m == 1, ram_rd_grant);
      `CHK("wr grant", m[0], ram_wr_grant);
      `CHK("high speed", m == 3, ram_high_speed);
    end
    acc(1'b0, STATUS_ADDR, 32'h0);
    `CHK("status idle", 32'h0, q);
    {ecc_disable_bit, program_active} = 2'h3;
    acc(1'b1, DUMMY_ECC_ADDR, 32'h1234_5678);
    acc(1'b0, STATUS_ADDR, 32'h0);
    `CHK("full set", 32'h0004_0000, q);
    fork
      acc(1'b1, DUMMY_ECC_ADDR, 32'h9abc_def0);
      begin
        repeat (3) @(negedge core_clk);
        `CHK("stall", 1, pbus_wait);
        `CHK("no ack", 0, pbus_ack);
        `CHK("kept", 32'h1234_5678, ecc_buf_data);
        ecc_buf_take = 1'b1;
        @(negedge core_clk);
        ecc_buf_take = 1'b0;
      end
    join
    `CHK("reload", 32'h9abc_def0, ecc_buf_data);
    @(negedge core_clk);
    ecc_buf_take = 1'b1;
    @(negedge core_clk);
    ecc_buf_take = 1'b0;
    acc(1'b0, STATUS_ADDR, 32'h0);
    `CHK("full clear", 32'h0, q);
    // generator path: dummy writes ignored, load and drain in one cycle stays full
    ecc_disable_bit = 1'b0;
    acc(1'b1, DUMMY_ECC_ADDR, 32'h0bad_0bad);
    `CHK("dummy ignored", 32'h9abc_def0, ecc_buf_data);
    {ecc_hw_load, ecc_hw_data} = {1'b1, 32'h5555_aaaa};
    @(negedge core_clk);
    {ecc_hw_load, ecc_buf_take} = 2'h3;
    @(negedge core_clk);
    {ecc_hw_load, ecc_buf_take} = 2'h0;
    `CHK("hw load", 32'h5555_aaaa, ecc_buf_data);
    acc(1'b0, STATUS_ADDR, 32'h0);
    `CHK("set beats take", 32'h0004_0000, q);
    ecc_buf_take = 1'b1;
    @(negedge core_clk);
    ecc_buf_take = 1'b0;
    // data flash commands never read the otp value
    cmd(CMD_PROGRAM);
    `CHK("data flash", 0, otp_read_req);
    // each otp reading command, double and single errors in turn
    target_code_flash = 1'b1;
    for (int c = 1; c < 6; c++)
    begin
      cmd(c[3:0]);
      `CHK("otp read", 1, otp_read_req);
      {otp_read_done, otp_err_double, otp_err_single} = {1'b1, c[0], !c[0]};
      @(negedge core_clk);
      otp_read_done = 1'b0;
      `CHK("lock", c[0], command_lock);
      acc(1'b0, STATUS_ADDR, 32'h0);
      `CHK("otp flag", c[0] ? 32'h0002_0000 : 32'h0001_0000, q);
      cmd(c[0] ? CMD_STATUS_CLEAR : CMD_FORCED_STOP);
      acc(1'b0, STATUS_ADDR, 32'h0);
      `CHK("otp clear", 32'h0, q | {31'h0, command_lock});
    end
    // mid-run reset while locked, with the ram enabled and requested
    cmd(CMD_PROGRAM);
    {otp_read_done, otp_err_double, otp_err_single} = 3'h6;
    @(negedge core_clk);
    otp_read_done = 1'b0;
    `CHK("locked", 1, command_lock);
    reset = 1'b1;
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    `CHK("reset grants", 0, {ram_rd_grant, ram_wr_grant, ram_high_speed});
    `CHK("reset otp", 0, {command_lock, otp_read_req});
    `CHK("reset buffer", 0, ecc_buf_data);
    acc(1'b0, RAME_ADDR, 32'h0);
    `CHK("reset enable", 0, q);
    acc(1'b0, STATUS_ADDR, 32'h0);
    `CHK("reset status", 0, q);
    give_verdict();
  end
endmodule
`default_nettype wire
